// ===== verilog/rct_pkg.sv
// Constants and types for countdown timer three
// What this block does
// R1: Halt-on-receive bit stops the running timer after the first four received bits.
// R2: Halt-on-receive is ignored while a trimming start mode is selected.
// R3: Start mode 00 never starts by itself; 01 starts at transmission end.
// R4: Modes 10 and 11 trim: start/stop on edges; 11 also underflows.
// R5: With reload-on-zero set, underflow reloads the reload word and keeps counting.
// R6: With reload-on-zero clear, the counter stops at zero until next start.
// R7: Every underflow sets the underflow interrupt flag.
// R8: Source 00 counts at 13.56 MHz; source 01 at 13.56 MHz divided by 64.
// R9: Source 10 counts timer zero underflows; source 11 counts timer one underflows.
// R10: Each start loads the counter from the reload high and low bytes.
// R11: Reload writes never disturb a running count; they apply at next start or at the next reload-on-zero underflow.
// R12: Live counter readable as high byte at 21h and low byte at 22h.
// R13: Software should not read the counter bytes during reception.
// R14: Wake-up control register at 23h holds running, change, trim, detect, restart, wake, source.
// R15: Wake-up expiry launches card detection when that bit is enabled.
// R16: A write changes the wake running bit only when the change-enable bit is set in that write.
// R17: A receive-halted timer keeps its count and raises no underflow until restarted.
// R18: In cascade mode each source underflow pulse decrements by exactly one.
// R19: Control bits 6 and 2 read zero and ignore writes.
package rct_pkg;
  localparam int WB_AW = 8;
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h1E;
  localparam logic [IDX_W-1:0] IDX_RLD_HI = 6'h1F;
  localparam logic [IDX_W-1:0] IDX_RLD_LO = 6'h20;
  localparam logic [IDX_W-1:0] IDX_CNT_HI = 6'h21;
  localparam logic [IDX_W-1:0] IDX_CNT_LO = 6'h22;
  localparam logic [IDX_W-1:0] IDX_WAKE = 6'h23;
  localparam logic [IDX_W-1:0] IDX_CMD = 6'h2F;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h30;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 6'h31;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN = 6'h32;
  localparam int CTRL_HALT_BIT = 7;
  localparam int CTRL_RELOAD_BIT = 3;
  localparam logic [7:0] CTRL_MASK = 8'hBB;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam int WK_ACTIVE = 7;
  localparam int WK_CHG = 6;
  localparam int WK_CD = 4;
  localparam int WK_RELOAD = 3;
  localparam logic [5:0] WAKE_RST = 6'h00;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int IRQ_UNDER = 0;
  localparam int IRQ_HALT = 1;
  localparam int PH_W = 27;
  localparam int SYS_FREQ_HZ = 100_000_000;
  localparam int FAST_FREQ_HZ = 13_560_000;
  localparam logic [PH_W-1:0] PH_STEP = PH_W'(FAST_FREQ_HZ);
  localparam logic [PH_W-1:0] PH_WRAP = PH_W'(SYS_FREQ_HZ);
  localparam logic [5:0] SLOW_LAST = 6'h3F;
  typedef enum logic [1:0] {
    START_MANUAL = 2'b00, START_TX_END = 2'b01,
    START_TRIM = 2'b10, START_TRIM_UF = 2'b11
  } rct_start_t;
  typedef enum logic [1:0] {
    SRC_FAST = 2'b00, SRC_SLOW = 2'b01, SRC_T0 = 2'b10, SRC_T1 = 2'b11
  } rct_src_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_HALT = 2'b10
  } rct_state_t;
endpackage

// ===== verilog/rct_tick_if.sv
// Count-rate strobes passed from the prescaler to the timer
`timescale 1ns/1ps
interface rct_tick_if;
  logic fast_tick;
  logic slow_tick;
  modport src (output fast_tick, output slow_tick);
  modport snk (input fast_tick, input slow_tick);
endinterface

// ===== verilog/rct_tick_gen.sv
// Prescaler making the 13.56 MHz and divided-by-64 strobes
`timescale 1ns/1ps
module rct_tick_gen (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, low
  rct_tick_if.src tk // Rate strobes
);
  import rct_pkg::*;
  logic [PH_W-1:0] acc;
  logic [5:0] div;
  logic [PH_W-1:0] sum;
  logic wrap;
  logic [PH_W-1:0] next_acc;
  // Fractional accumulator: average rate exact, jitter one system cycle
  assign sum = acc + PH_STEP;
  assign wrap = sum >= PH_WRAP;
  assign next_acc = wrap ? sum - PH_WRAP : sum;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      div <= '0;
      tk.fast_tick <= 1'b0;
      tk.slow_tick <= 1'b0;
    end else begin
      acc <= next_acc;
      tk.fast_tick <= wrap; // [R8]
      tk.slow_tick <= wrap && (div == SLOW_LAST); // [R8]
      if (wrap) begin
        div <= div + 6'h01;
      end
    end
  end
  fast_spacing_a: assert property (@(posedge clk) disable iff (!rst_n)
    tk.fast_tick |=> !tk.fast_tick ##1 !tk.fast_tick) // [R8]
    else $error("fast strobes closer than three cycles");
endmodule // rct_tick_gen

// ===== verilog/rct_timer3_top.sv
// Countdown timer three with wake-up control and Wishbone registers
`timescale 1ns/1ps
module rct_timer3_top (
  input wire logic SYS_CLK, // 100 MHz clock
  input wire logic RST_N, // Async reset, low
  input wire logic WB_CYC_I, // Bus cycle
  input wire logic WB_STB_I, // Bus strobe
  input wire logic WB_WE_I, // Write enable
  input wire logic [rct_pkg::WB_AW-1:0] WB_ADR_I, // Byte address
  input wire logic [3:0] WB_SEL_I, // Byte lanes
  input wire logic [31:0] WB_DAT_I, // Write data
  output logic [31:0] WB_DAT_O, // Read data
  output logic WB_ACK_O, // Acknowledge
  input wire logic TX_END, // Transmission ended, pulse
  input wire logic RX_NIBBLE, // First four bits received, pulse
  input wire logic LFO_EDGE, // Oscillator rising edge, pulse
  input wire logic T0_UNDERFLOW, // Timer zero underflow, pulse
  input wire logic T1_UNDERFLOW, // Timer one underflow, pulse
  input wire logic WAKE_EXPIRE, // Wake-up timer underflow, pulse
  output logic IRQ, // Interrupt, level
  output logic UNDERFLOW, // Underflow pulse for cascading
  output logic CARD_DETECT_START, // Launch card detection, pulse
  output logic WAKE_ACTIVE // Wake-up timer running
);
  import rct_pkg::*;

  function automatic logic hit(input logic [IDX_W-1:0] a, input logic [IDX_W-1:0] k);
    hit = (a == k);
  endfunction

  rct_tick_if tk ();
  rct_tick_gen u_tick (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .tk(tk)
  );

  logic [7:0] ctrl;
  logic [7:0] reload_high_byte;
  logic [7:0] reload_low_byte;
  logic [5:0] wake_ctrl;
  logic wake_timer_active;
  logic [15:0] count;
  rct_state_t state;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;

  // Bus decode
  logic [IDX_W-1:0] idx;
  logic req;
  logic wr;
  logic [7:0] wdat;
  assign idx = WB_ADR_I[WB_AW-1:2];
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // Write lands at the edge where the master samples ack
  assign wr = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  assign wdat = WB_DAT_I[7:0];
  logic wr_ctrl;
  logic wr_rhi;
  logic wr_rlo;
  logic wr_wake;
  logic wr_cmd;
  logic wr_clr;
  logic wr_en;
  assign wr_ctrl = wr && hit(idx, IDX_CTRL);
  assign wr_rhi = wr && hit(idx, IDX_RLD_HI);
  assign wr_rlo = wr && hit(idx, IDX_RLD_LO);
  assign wr_wake = wr && hit(idx, IDX_WAKE);
  assign wr_cmd = wr && hit(idx, IDX_CMD);
  assign wr_clr = wr && hit(idx, IDX_IRQ_CLR);
  assign wr_en = wr && hit(idx, IDX_IRQ_EN);

  // Control field view
  logic halt_on_receive;
  rct_start_t start_trigger_select;
  logic reload_on_zero;
  rct_src_t count_source_select;
  logic [15:0] reload_word;
  assign halt_on_receive = ctrl[CTRL_HALT_BIT];
  assign start_trigger_select = rct_start_t'(ctrl[5:4]);
  assign reload_on_zero = ctrl[CTRL_RELOAD_BIT];
  assign count_source_select = rct_src_t'(ctrl[1:0]);
  assign reload_word = {reload_high_byte, reload_low_byte}; // [R10]

  // Count strobe selection
  logic tick;
  assign tick = (count_source_select == SRC_FAST) ? tk.fast_tick : // [R8]
                (count_source_select == SRC_SLOW) ? tk.slow_tick : // [R8]
                (count_source_select == SRC_T0) ? T0_UNDERFLOW : // [R9] [R18]
                T1_UNDERFLOW; // [R9] [R18]

  // Start and stop events
  logic running;
  logic trim;
  logic sw_start;
  logic sw_stop;
  logic rx_halt;
  logic start_evt;
  logic stop_evt;
  logic at_zero;
  logic underflow;
  assign running = (state == ST_RUN);
  assign trim = start_trigger_select[1]; // [R4]
  assign sw_start = wr_cmd && wdat[CMD_START_BIT];
  assign sw_stop = wr_cmd && wdat[CMD_STOP_BIT];
  assign rx_halt = running && halt_on_receive && !trim && RX_NIBBLE; // [R1] [R2]
  assign start_evt = sw_start ||
                     (start_trigger_select == START_TX_END && TX_END) || // [R3]
                     (trim && LFO_EDGE && !running); // [R4]
  assign stop_evt = sw_stop || rx_halt || (trim && LFO_EDGE && running); // [R4]
  assign at_zero = (count == 16'h0000);
  // Trimming without underflow parks at zero until the closing edge
  assign underflow = running && tick && at_zero && !stop_evt &&
                     (start_trigger_select != START_TRIM); // [R4]

  rct_state_t next_state;
  logic [15:0] next_count;
  always_comb begin
    next_state = state;
    next_count = count;
    if (stop_evt) begin
      next_state = rx_halt ? ST_HALT : ST_IDLE; // [R17]
    end else if (start_evt) begin
      next_state = ST_RUN;
      next_count = reload_word; // [R10] [R11]
    end else if (underflow) begin
      if (reload_on_zero) begin
        next_count = reload_word; // [R5]
      end else begin
        next_state = ST_IDLE; // [R6]
      end
    end else if (running && tick && !at_zero) begin
      next_count = count - 16'h0001; // [R18]
    end
  end

  // Interrupt status, set wins over clear
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] next_irq_stat;
  assign irq_set = {rx_halt, underflow}; // [R7]
  assign next_irq_stat = (irq_stat & ~(wr_clr ? wdat[IRQ_W-1:0] : '0)) | irq_set;

  // Wake-up running flag
  logic wake_stop;
  logic next_wake_active;
  assign wake_stop = WAKE_EXPIRE && wake_timer_active && !wake_ctrl[WK_RELOAD];
  assign next_wake_active = (wr_wake && wdat[WK_CHG]) ? wdat[WK_ACTIVE] : // [R16]
                            wake_stop ? 1'b0 : wake_timer_active;

  // Read selection
  logic [7:0] rd_byte;
  always_comb begin
    unique case (idx)
      IDX_CTRL: rd_byte = ctrl & CTRL_MASK; // [R19]
      IDX_RLD_HI: rd_byte = reload_high_byte;
      IDX_RLD_LO: rd_byte = reload_low_byte;
      IDX_CNT_HI: rd_byte = count[15:8]; // [R12]
      IDX_CNT_LO: rd_byte = count[7:0]; // [R12]
      IDX_WAKE: rd_byte = {wake_timer_active, 1'b0, wake_ctrl}; // [R14]
      IDX_CMD: rd_byte = {6'h00, state == ST_HALT, running};
      IDX_IRQ_STAT: rd_byte = {6'h00, irq_stat};
      IDX_IRQ_EN: rd_byte = {6'h00, irq_en};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= req;
      WB_DAT_O <= {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= CTRL_RST;
      reload_high_byte <= RELOAD_RST;
      reload_low_byte <= RELOAD_RST;
      irq_en <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wdat & CTRL_MASK; // [R19]
      end
      if (wr_rhi) begin
        reload_high_byte <= wdat; // [R11]
      end
      if (wr_rlo) begin
        reload_low_byte <= wdat; // [R11]
      end
      if (wr_en) begin
        irq_en <= wdat[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      count <= 16'h0000;
      irq_stat <= '0;
      UNDERFLOW <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      irq_stat <= next_irq_stat;
      UNDERFLOW <= underflow; // [R7]
      IRQ <= |(next_irq_stat & irq_en);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wake_ctrl <= WAKE_RST;
      wake_timer_active <= 1'b0;
      WAKE_ACTIVE <= 1'b0;
      CARD_DETECT_START <= 1'b0;
    end else begin
      if (wr_wake) begin
        wake_ctrl <= wdat[5:0]; // [R14]
      end
      wake_timer_active <= next_wake_active;
      WAKE_ACTIVE <= next_wake_active;
      CARD_DETECT_START <= WAKE_EXPIRE && wake_timer_active && wake_ctrl[WK_CD]; // [R15]
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence halted_s;
    state == ST_HALT && !start_evt && !sw_stop;
  endsequence
  sequence quiet_s;
    !UNDERFLOW && state == ST_HALT;
  endsequence

  rx_halt_stop_a: assert property (rx_halt |=> state == ST_HALT) // [R1]
    else $error("receive halt did not stop timer");
  trim_ignores_halt_a: assert property ( // [R2]
    running && trim && halt_on_receive && RX_NIBBLE && !LFO_EDGE && !sw_stop && !underflow
    |=> running) else $error("trimming timer halted by reception");
  manual_no_start_a: assert property ( // [R3]
    start_trigger_select == START_MANUAL && !running && !sw_start |=> !running)
    else $error("manual mode started by itself");
  tx_start_load_a: assert property ( // [R3]
    start_trigger_select == START_TX_END && TX_END && !stop_evt
    |=> running && count == $past(reload_word)) else $error("no start at tx end");
  auto_reload_a: assert property ( // [R5]
    underflow && reload_on_zero |=> running && count == $past(reload_word))
    else $error("auto reload missing");
  stop_at_zero_a: assert property ( // [R6]
    underflow && !reload_on_zero && !start_evt |=> !running && count == 16'h0000)
    else $error("timer did not stop at zero");
  underflow_flag_a: assert property ( // [R7]
    underflow |=> irq_stat[IRQ_UNDER] && UNDERFLOW) else $error("underflow flag not set");
  cascade_step_a: assert property ( // [R18]
    running && count_source_select == SRC_T0 && T0_UNDERFLOW && !at_zero &&
    !start_evt && !stop_evt |=> count == $past(count) - 16'h0001)
    else $error("cascade step not exactly one");
  halt_holds_a: assert property ( // [R17]
    halted_s |=> quiet_s and count == $past(count)) else $error("halted timer moved");
  wake_guard_a: assert property ( // [R16]
    wr_wake && !wdat[WK_CHG] && !WAKE_EXPIRE |=> WAKE_ACTIVE == $past(WAKE_ACTIVE))
    else $error("wake running changed without enable");
endmodule // rct_timer3_top

// ===== bench/tb.sv
// Self-checking bench for countdown timer three
`timescale 1ns/1ps
module tb;
  import rct_pkg::*;
  localparam int E_TX = 0;
  localparam int E_RX = 1;
  localparam int E_LFO = 2;
  localparam int E_T0 = 3;
  localparam int E_T1 = 4;
  localparam int E_WK = 5;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [5:0] ev = 6'h00;
  logic [31:0] dat_o;
  logic ack, irq, uf, cds, wact;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int uf_seen = 0;
  int cd_seen = 0;

  always #5 sys_clk = ~sys_clk;

  rct_timer3_top rct_timer3_top_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .TX_END(ev[E_TX]), .RX_NIBBLE(ev[E_RX]),
    .LFO_EDGE(ev[E_LFO]), .T0_UNDERFLOW(ev[E_T0]), .T1_UNDERFLOW(ev[E_T1]),
    .WAKE_EXPIRE(ev[E_WK]), .IRQ(irq), .UNDERFLOW(uf), .CARD_DETECT_START(cds),
    .WAKE_ACTIVE(wact));

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (uf === 1'b1) uf_seen <= uf_seen + 1;
    if (cds === 1'b1) cd_seen <= cd_seen + 1;
    if (cycles == 40000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Checks done %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Classic single cycle; held until ack is sampled, then released for a cycle
  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    dat <= {24'h0, d};
    @(posedge sys_clk);
    while (ack !== 1'b1 && n < 100) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 100) miscompares++;
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, q);
    check({8'h00, q}, {8'h00, exp});
  endtask

  // Counter bytes are read only outside reception
  task automatic cnt_chk(input logic [15:0] exp);
    rd_chk(IDX_CNT_HI, exp[15:8]);
    rd_chk(IDX_CNT_LO, exp[7:0]);
  endtask

  task automatic pulse(input int b);
    @(posedge sys_clk);
    ev[b] <= 1'b1;
    @(posedge sys_clk);
    ev[b] <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  function automatic logic [7:0] ctl(input logic h, input rct_start_t st, input logic r,
                                     input rct_src_t s);
    return {h, 1'b0, st, r, 1'b0, s};
  endfunction

  task automatic s_regs();
    rd_chk(IDX_CTRL, CTRL_RST);
    wr(IDX_CTRL, 8'hFF);
    rd_chk(IDX_CTRL, CTRL_MASK);
    wr(IDX_RLD_HI, 8'hA5);
    wr(IDX_RLD_LO, 8'h5A);
    rd_chk(IDX_RLD_HI, 8'hA5);
    rd_chk(IDX_RLD_LO, 8'h5A);
    wr(IDX_CNT_HI, 8'hFF);
    rd_chk(IDX_CNT_HI, 8'h00);
    rd_chk(6'h3F, 8'h00);
  endtask

  task automatic s_cascade();
    wr(IDX_CTRL, ctl(1'b0, START_MANUAL, 1'b0, SRC_T0));
    wr(IDX_RLD_HI, 8'h01);
    wr(IDX_RLD_LO, 8'h02);
    pulse(E_TX);
    cnt_chk(16'h0000);
    wr(IDX_CMD, 8'h01);
    cnt_chk(16'h0102);
    pulse(E_T0);
    cnt_chk(16'h0101);
    pulse(E_T1);
    cnt_chk(16'h0101);
    wr(IDX_CTRL, ctl(1'b0, START_MANUAL, 1'b0, SRC_T1));
    pulse(E_T1);
    wr(IDX_RLD_LO, 8'h09);
    pulse(E_T1);
    cnt_chk(16'h00FF);
    wr(IDX_CMD, 8'h02);
  endtask

  task automatic s_underflow();
    int u;
    wr(IDX_CTRL, ctl(1'b0, START_MANUAL, 1'b1, SRC_T0));
    wr(IDX_RLD_HI, 8'h00);
    wr(IDX_RLD_LO, 8'h01);
    wr(IDX_IRQ_CLR, 8'h03);
    wr(IDX_IRQ_EN, 8'h01);
    wr(IDX_CMD, 8'h01);
    pulse(E_T0);
    check({15'h0, irq}, 16'h0000);
    u = uf_seen;
    pulse(E_T0);
    check(16'(uf_seen - u), 16'h0001);
    check({15'h0, irq}, 16'h0001);
    cnt_chk(16'h0001);
    wr(IDX_IRQ_EN, 8'h00);
    rd_chk(IDX_IRQ_STAT, 8'h01);
    check({15'h0, irq}, 16'h0000);
    wr(IDX_IRQ_EN, 8'h01);
    wr(IDX_IRQ_CLR, 8'h01);
    rd_chk(IDX_IRQ_STAT, 8'h00);
    check({15'h0, irq}, 16'h0000);
  endtask

  task automatic s_stop_zero();
    int u;
    wr(IDX_CTRL, ctl(1'b0, START_MANUAL, 1'b0, SRC_T0));
    wr(IDX_RLD_LO, 8'h02);
    wr(IDX_CMD, 8'h01);
    u = uf_seen;
    repeat (4) pulse(E_T0);
    check(16'(uf_seen - u), 16'h0001);
    cnt_chk(16'h0000);
    rd_chk(IDX_CMD, 8'h00);
  endtask

  task automatic s_halt();
    wr(IDX_CTRL, ctl(1'b1, START_TX_END, 1'b0, SRC_T0));
    wr(IDX_RLD_LO, 8'h05);
    pulse(E_TX);
    cnt_chk(16'h0005);
    pulse(E_T0);
    pulse(E_RX);
    pulse(E_T0);
    cnt_chk(16'h0004);
    rd_chk(IDX_CMD, 8'h02);
    rd_chk(IDX_IRQ_STAT, 8'h03);
    // Trimming mode: the receive halt bit must be ignored
    wr(IDX_CTRL, ctl(1'b1, START_TRIM, 1'b0, SRC_T0));
    wr(IDX_CMD, 8'h02);
    pulse(E_LFO);
    pulse(E_RX);
    pulse(E_T0);
    cnt_chk(16'h0004);
    pulse(E_LFO);
    pulse(E_T0);
    cnt_chk(16'h0004);
  endtask

  // Trim without underflow parks at zero; with underflow it expires
  task automatic s_trim();
    int u;
    wr(IDX_RLD_LO, 8'h01);
    wr(IDX_CTRL, ctl(1'b0, START_TRIM, 1'b0, SRC_T0));
    u = uf_seen;
    pulse(E_LFO);
    repeat (3) pulse(E_T0);
    cnt_chk(16'h0000);
    check(16'(uf_seen - u), 16'h0000);
    rd_chk(IDX_CMD, 8'h01);
    pulse(E_LFO);
    rd_chk(IDX_CMD, 8'h00);
    wr(IDX_CTRL, ctl(1'b0, START_TRIM_UF, 1'b0, SRC_T0));
    pulse(E_LFO);
    repeat (2) pulse(E_T0);
    check(16'(uf_seen - u), 16'h0001);
    rd_chk(IDX_CMD, 8'h00);
  endtask

  // Fractional prescaler allows one count of jitter either way
  task automatic s_rate(input rct_src_t s, input int wait_c);
    logic [7:0] a, b;
    int t, e, d;
    wr(IDX_CTRL, ctl(1'b0, START_MANUAL, 1'b0, s));
    wr(IDX_RLD_HI, 8'hFF);
    wr(IDX_RLD_LO, 8'hFF);
    wr(IDX_CMD, 8'h01);
    wb(1'b0, IDX_CNT_LO, 8'h00, a);
    t = cycles;
    repeat (wait_c) @(posedge sys_clk);
    wb(1'b0, IDX_CNT_LO, 8'h00, b);
    d = int'(8'(a - b));
    e = (cycles - t) * 1356 / ((s == SRC_FAST) ? 10000 : 640000);
    check(16'(d >= e - 1 && d <= e + 1), 16'h0001);
    wr(IDX_CMD, 8'h02);
  endtask

  task automatic s_wake();
    int c;
    wr(IDX_WAKE, 8'h80);
    rd_chk(IDX_WAKE, 8'h00);
    wr(IDX_WAKE, 8'hD8);
    rd_chk(IDX_WAKE, 8'h98);
    check({15'h0, wact}, 16'h0001);
    c = cd_seen;
    pulse(E_WK);
    check(16'(cd_seen - c), 16'h0001);
    wr(IDX_WAKE, 8'h10);
    rd_chk(IDX_WAKE, 8'h90);
    pulse(E_WK);
    check(16'(cd_seen - c), 16'h0002);
    rd_chk(IDX_WAKE, 8'h10);
    wr(IDX_WAKE, 8'hC0);
    pulse(E_WK);
    check(16'(cd_seen - c), 16'h0002);
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    s_regs();
    s_cascade();
    s_underflow();
    s_stop_zero();
    s_halt();
    s_trim();
    s_rate(SRC_FAST, 1000);
    s_rate(SRC_SLOW, 10000);
    s_wake();
    print_verdict();
  end
endmodule // tb
